// >>> include/cca_pkg.sv
package cca_pkg;
    // Channel count and register byte offsets
    localparam int NCH = 6;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FLAG = 8'h04;
    localparam logic [7:0] OFS_PCFG = 8'h08;
    localparam logic [7:0] OFS_CNT = 8'h0C;
    localparam logic [7:0] OFS_PIN = 8'h10;
    localparam logic [7:0] OFS_MODE = 8'h20;
    localparam logic [7:0] OFS_CMPL = 8'h40;
    localparam logic [7:0] OFS_CMPH = 8'h60;
    // Channel mode register bit positions
    localparam int MB_IRQ = 0;
    localparam int MB_PULSE = 1;
    localparam int MB_TOG = 2;
    localparam int MB_MAT = 3;
    localparam int MB_FALL = 4;
    localparam int MB_RISE = 5;
    localparam int MB_CMP = 6;
    localparam int MB_WIDE = 7;
    // Array control register bit positions
    localparam int CT_RUN = 0;
    localparam int CT_WRAP_IE = 1;
    localparam int CT_ARRAY_IE = 2;
    localparam int CT_GLOBAL_IE = 3;
    // Pulse configuration register bit positions
    localparam int PC_CLS = 0;
    localparam int PC_PWIE = 5;
    localparam int PC_RVIEW = 7;
    // Flag register bit positions
    localparam int FL_WRAP = 0;
    localparam int FL_PART = 1;
    localparam int FL_CH = 2;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] PCFG_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [15:0] CCR_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;

    // Complete state of the unit, registered as one word
    typedef struct packed {
        logic [15:0] cnt;
        logic [7:0] ctrl;
        logic [7:0] pcfg;
        logic [7:0] flags;
        logic [NCH-1:0][7:0] mode;
        logic [NCH-1:0][15:0] ccr;
        logic [NCH-1:0][15:0] arr;
        logic [NCH-1:0] pin_prev;
        logic [NCH-1:0] pin_out;
        logic irq;
        logic [31:0] rdata;
        logic wr_pend;
        logic [7:0] wr_addr;
    } cca_state_type;
endpackage : cca_pkg

// >>> rtl/cca_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Full 16-bit counter overflow sets wrap flag.
// - Overflow out of bit 7-10 sets partial flag.
// - Flags set on trigger regardless of interrupt enables.
// - Each flag requests interrupt only when enabled.
// - Interrupt needs global and array enables both.
// - Each channel independently runs one of six modes.
// - Short pulse modes share one cycle length.
// - Cycle length select picks 8 to 11 bits.
// - Rise, fall or both edges select capture.
// - Wide bit plus pulse bit gives 16-bit pulse.
// - Reload view redirects compare bytes to reload.
// - Comparator off: no toggle, pulse output low.
// - Match flag enable lets matches set flag.
// - Capture copies counter and sets channel flag.
// - Channel flag cleared only by software write.
// - Pin level stays readable for edge discrimination.
// - Software timer flags counter equal compare.
// - Low byte write disables, high enables comparator.
// - High-speed output toggles pin on each match.
// - Comparator off holds high-speed pin level.
// - Counter wraps from maximum to zero.
module cca_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic [5:0] i_pin,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [5:0] o_pin,
    output logic o_irq
);
    ////////////////////////////////////////////////////////////////////////
    cca_pkg::cca_state_type r; // Registered state
    cca_pkg::cca_state_type next_r; // Next state
    logic [15:0] mask; // Low counter bits of the short cycle
    logic inc; // Counter advances this cycle
    logic wrap; // Full counter wrap
    logic part; // Short cycle overflow
    logic [5:0] m16; // Full compare match
    logic [5:0] mn; // Short compare match
    logic [5:0] cap; // Qualifying capture edge
    logic [5:0] hw_set; // Hardware sets of channel flags
    logic [5:0] wr_cl; // Compare low byte written
    logic [5:0] en_v; // Channel interrupt enables
    logic [7:0] wa; // Write address byte
    logic [7:0] ra; // Read address byte
    logic bus_rd; // Address phase of a read

    // Short cycle mask from the shared cycle length
    function automatic logic [15:0] low_mask(input logic [1:0] cls);
        case (cls)
            2'h0: low_mask = 16'h00FF;
            2'h1: low_mask = 16'h01FF;
            2'h2: low_mask = 16'h03FF;
            default: low_mask = 16'h07FF;
        endcase
    endfunction : low_mask

    // Channel index decoded from a channel-array address
    function automatic int chan(input logic [7:0] a);
        chan = int'(a[4:2]);
    endfunction : chan

    // Register read multiplexer
    function automatic logic [31:0] rd_mux(input cca_pkg::cca_state_type s,
        input logic [7:0] a, input logic [5:0] pin);
        int n;
        logic rv;
        n = chan(a);
        rv = s.pcfg[cca_pkg::PC_RVIEW];
        rd_mux = 32'h0000_0000;
        if (a == cca_pkg::OFS_CTRL)
            rd_mux[7:0] = s.ctrl;
        else if (a == cca_pkg::OFS_FLAG)
            rd_mux[7:0] = s.flags;
        else if (a == cca_pkg::OFS_PCFG)
            rd_mux[7:0] = s.pcfg;
        else if (a == cca_pkg::OFS_CNT)
            rd_mux[15:0] = s.cnt;
        else if (a == cca_pkg::OFS_PIN)
            rd_mux[5:0] = pin;
        else if (n < cca_pkg::NCH && a[1:0] == 2'h0)
        begin
            // Reload view picks which compare copy is seen
            if (a[7:5] == cca_pkg::OFS_MODE[7:5])
                rd_mux[7:0] = s.mode[n];
            else if (a[7:5] == cca_pkg::OFS_CMPL[7:5])
                rd_mux[7:0] = rv ? s.arr[n][7:0] : s.ccr[n][7:0];
            else if (a[7:5] == cca_pkg::OFS_CMPH[7:5])
                rd_mux[7:0] = rv ? s.arr[n][15:8] : s.ccr[n][15:8];
        end
    endfunction : rd_mux

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic: bus writes first, hardware events after, so
    // an event in the same cycle as a software clear is never lost
    always_comb
    begin
        next_r = r;
        wa = r.wr_addr;
        ra = i_haddr[7:0];
        bus_rd = i_hsel && i_htrans[1] && i_hready && !i_hwrite;
        wr_cl = 6'h00;
        hw_set = 6'h00;
        m16 = 6'h00;
        mn = 6'h00;
        cap = 6'h00;
        en_v = 6'h00;
        mask = low_mask(r.pcfg[1:0]);
        inc = r.ctrl[cca_pkg::CT_RUN];
        wrap = inc && (r.cnt == cca_pkg::CNT_MAX);
        part = inc && ((r.cnt & mask) == mask);

        // Data phase of a write
        if (r.wr_pend)
        begin
            if (wa == cca_pkg::OFS_CTRL)
                next_r.ctrl = i_hwdata[7:0];
            else if (wa == cca_pkg::OFS_FLAG)
                next_r.flags = r.flags & ~i_hwdata[7:0];
            else if (wa == cca_pkg::OFS_PCFG)
                next_r.pcfg = i_hwdata[7:0];
            else if (chan(wa) < cca_pkg::NCH && wa[1:0] == 2'h0)
            begin
                if (wa[7:5] == cca_pkg::OFS_MODE[7:5])
                    next_r.mode[chan(wa)] = i_hwdata[7:0];
                else if (wa[7:5] == cca_pkg::OFS_CMPL[7:5])
                begin
                    wr_cl[chan(wa)] = 1'b1;
                    next_r.mode[chan(wa)][cca_pkg::MB_CMP] = 1'b0;
                    if (r.pcfg[cca_pkg::PC_RVIEW])
                        next_r.arr[chan(wa)][7:0] = i_hwdata[7:0];
                    else
                        next_r.ccr[chan(wa)][7:0] = i_hwdata[7:0];
                end
                else if (wa[7:5] == cca_pkg::OFS_CMPH[7:5])
                begin
                    next_r.mode[chan(wa)][cca_pkg::MB_CMP] = 1'b1;
                    if (r.pcfg[cca_pkg::PC_RVIEW])
                        next_r.arr[chan(wa)][15:8] = i_hwdata[7:0];
                    else
                        next_r.ccr[chan(wa)][15:8] = i_hwdata[7:0];
                end
            end
        end

        // Shared counter wraps from maximum to zero
        if (inc)
            next_r.cnt = r.cnt + 16'h0001;
        if (wrap)
            next_r.flags[cca_pkg::FL_WRAP] = 1'b1;
        if (part)
            next_r.flags[cca_pkg::FL_PART] = 1'b1;

        // Per-channel mode behaviour
        for (int i = 0; i < cca_pkg::NCH; i++)
        begin
            en_v[i] = r.mode[i][cca_pkg::MB_IRQ];
            m16[i] = r.mode[i][cca_pkg::MB_CMP] && (r.cnt == r.ccr[i]);
            mn[i] = r.mode[i][cca_pkg::MB_CMP] && ((r.cnt & mask) == (r.ccr[i] & mask));
            if (r.mode[i][3:1] == 3'h0)
            begin
                // Edge capture; pin taken as synchronous
                cap[i] = (r.mode[i][cca_pkg::MB_RISE] && i_pin[i] && !r.pin_prev[i])
                    || (r.mode[i][cca_pkg::MB_FALL] && !i_pin[i] && r.pin_prev[i]);
                if (cap[i])
                begin
                    next_r.ccr[i] = r.cnt;
                    hw_set[i] = 1'b1;
                end
            end
            else if (r.mode[i][cca_pkg::MB_PULSE] && !r.mode[i][cca_pkg::MB_TOG])
            begin
                if (!r.mode[i][cca_pkg::MB_CMP])
                    next_r.pin_out[i] = 1'b0;
                else if (r.mode[i][cca_pkg::MB_WIDE])
                begin
                    // Wide pulse: high at match, low at full wrap
                    if (m16[i])
                        next_r.pin_out[i] = 1'b1;
                    else if (wrap)
                        next_r.pin_out[i] = 1'b0;
                end
                else
                begin
                    // Short pulse: high at match, low at short overflow
                    if (mn[i])
                        next_r.pin_out[i] = 1'b1;
                    else if (part)
                        next_r.pin_out[i] = 1'b0;
                end
                hw_set[i] = r.mode[i][cca_pkg::MB_MAT]
                    && (r.mode[i][cca_pkg::MB_WIDE] ? m16[i] : mn[i]);
                // Short overflow reloads the compare value
                if (!r.mode[i][cca_pkg::MB_WIDE] && part && !wr_cl[i])
                begin
                    if (r.pcfg[1:0] == 2'h0)
                        next_r.ccr[i][7:0] = r.ccr[i][15:8];
                    else
                        next_r.ccr[i] = r.arr[i];
                end
            end
            else if (r.mode[i][cca_pkg::MB_TOG] && r.mode[i][cca_pkg::MB_PULSE])
            begin
                // Frequency output: low byte match toggles, steps by high byte
                if (r.mode[i][cca_pkg::MB_CMP] && r.cnt[7:0] == r.ccr[i][7:0])
                begin
                    next_r.pin_out[i] = !r.pin_out[i];
                    next_r.ccr[i][7:0] = r.ccr[i][7:0] + r.ccr[i][15:8];
                end
                hw_set[i] = r.mode[i][cca_pkg::MB_MAT] && m16[i];
            end
            else
            begin
                // Software timer and high-speed output; no toggle when off
                if (r.mode[i][cca_pkg::MB_TOG] && m16[i])
                    next_r.pin_out[i] = !r.pin_out[i];
                hw_set[i] = r.mode[i][cca_pkg::MB_MAT] && m16[i];
            end
            if (hw_set[i])
                next_r.flags[cca_pkg::FL_CH + i] = 1'b1;
        end
        next_r.pin_prev = i_pin;

        // One level request from enabled flags
        next_r.irq = r.ctrl[cca_pkg::CT_GLOBAL_IE] && r.ctrl[cca_pkg::CT_ARRAY_IE]
            && |(r.flags & {en_v, r.pcfg[cca_pkg::PC_PWIE],
            r.ctrl[cca_pkg::CT_WRAP_IE]});

        // Address phase: zero wait states, reads answered next cycle
        next_r.wr_pend = i_hsel && i_htrans[1] && i_hready && i_hwrite;
        next_r.wr_addr = i_haddr[7:0];
        if (bus_rd)
            next_r.rdata = rd_mux(r, ra, i_pin);
        else
            next_r.rdata = 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            r <= '0;
            r.ctrl <= cca_pkg::CTRL_RST;
            r.pcfg <= cca_pkg::PCFG_RST;
        end
        else
            r <= next_r;
    end

    // Outputs straight from state; slave always ready and OKAY
    assign o_hrdata = r.rdata;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_pin = r.pin_out;
    assign o_irq = r.irq;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the shared flags and on the channels that the bench drives
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_wrap;
        (r.ctrl[0] && r.cnt == 16'hFFFF) |=> (r.cnt == 16'h0000) && r.flags[0];
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap missed");

    property p_part;
        part |=> r.flags[1];
    endproperty
    a_part: assert property (p_part) else $error("partial wrap missed");

    property p_cap;
        cap[2] |=> (r.ccr[2] == $past(r.cnt)) && r.flags[4];
    endproperty
    a_cap: assert property (p_cap) else $error("capture wrong");

    property p_low;
        (r.wr_pend && r.wr_addr == 8'h40) |=> !r.mode[0][6];
    endproperty
    a_low: assert property (p_low) else $error("comparator left on");

    property p_setwin;
        hw_set[0] |=> r.flags[2];
    endproperty
    a_setwin: assert property (p_setwin) else $error("event lost");

    property p_irq;
        (r.ctrl[3] && r.ctrl[2] && r.flags[0] && r.ctrl[1]) |=> o_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_noirq;
        !r.ctrl[3] |=> !o_irq;
    endproperty
    a_noirq: assert property (p_noirq) else $error("irq not gated");

    property p_hold;
        (r.mode[1][2:1] == 2'h2 && !r.mode[1][6]) |=> o_pin[1] == $past(o_pin[1]);
    endproperty
    a_hold: assert property (p_hold) else $error("pin moved");

    property p_tog;
        (r.mode[1][3:1] == 3'h6 && m16[1]) |=> o_pin[1] != $past(o_pin[1]) && r.flags[3];
    endproperty
    a_tog: assert property (p_tog) else $error("toggle missed");

    property p_pwmoff;
        (r.mode[4][2:1] == 2'h1 && r.mode[4][5:4] == 2'h0 && !r.mode[4][6]) |=> !o_pin[4];
    endproperty
    a_pwmoff: assert property (p_pwmoff) else $error("pulse not low");

    property p_short;
        (r.mode[4][7:6] == 2'h1 && r.mode[4][2:1] == 2'h1 && r.mode[4][5:4] == 2'h0 && mn[4])
            |=> o_pin[4];
    endproperty
    a_short: assert property (p_short) else $error("short pulse not raised");

    property p_wide;
        (r.mode[4][7:6] == 2'h3 && r.mode[4][2:1] == 2'h1 && m16[4]) |=> o_pin[4];
    endproperty
    a_wide: assert property (p_wide) else $error("wide pulse not raised");

    property p_keep;
        (r.flags[2] && !(r.wr_pend && r.wr_addr == 8'h04)) |=> r.flags[2];
    endproperty
    a_keep: assert property (p_keep) else $error("channel flag dropped");

    property p_rview;
        (r.wr_pend && r.wr_addr == 8'h4C && r.pcfg[7]) |=> r.arr[3][7:0] == $past(i_hwdata[7:0]);
    endproperty
    a_rview: assert property (p_rview) else $error("reload copy not written");
endmodule : cca_top

// >>> verif/cca_pin_model.sv
`timescale 1ns/1ps
// Drives the six channel pins from the outside world.
// A requested level is passed on only after the previous one has stood
// for two clocks, so a fast request is delayed, and is dropped if it is withdrawn before then.
module cca_pin_model (
    input wire logic i_clk,
    input wire logic [5:0] i_level,
    output logic [5:0] o_pin
);
    // Cycles the present level must still stand
    logic [1:0] hold = 2'h0;
    // Level presently shown on the pins
    logic [5:0] lvl_q = 6'h00;

    assign o_pin = lvl_q;

    ////////////////////////////////////////////////////////////////////////
    // Pass a new level on, then hold it for at least two clocks
    always @(posedge i_clk)
    begin
        if (hold != 2'h0)
        begin
            hold <= hold - 2'h1;
        end
        else if (i_level != lvl_q)
        begin
            lvl_q <= i_level;
            hold <= 2'h1;
        end
    end
endmodule : cca_pin_model

// >>> verif/counter_array_capture_compare_tb_top.sv
`timescale 1ns/1ps
module counter_array_capture_compare_tb_top;
    // Clock, reset and bus master signals
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic [5:0] lvl = 6'h00;
    logic [5:0] pin_in;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic [5:0] pin_out;
    logic irq;
    // Bookkeeping
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic [15:0] c;

    // The wrap test needs a full 65536-cycle lap; the ceiling leaves margin
    localparam int LIMIT = 95000;

    always #12.5 i_clk = ~i_clk;

    cca_pin_model pins (.i_clk(i_clk), .i_level(lvl), .o_pin(pin_in));

    cca_top dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .i_pin(pin_in), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .o_pin(pin_out), .o_irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // Reporting
    task print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [31:0] b(input logic x);
        return {31'h00000000, x};
    endfunction : b

    // Hang guard
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            n_errors++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus cycles: address phase held until hready, then the data phase
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        @(posedge i_clk);
        while (hready !== 1'b1) @(posedge i_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge i_clk);
        while (hready !== 1'b1) @(posedge i_clk);
        rd = hrdata;
    endtask : bus

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        check(rd, exp);
    endtask : rdc

    // Poll the flag register until one bit shows, bounded by read count
    task wait_flag(input int n, input int lim);
        rd = 32'h00000000;
        for (int i = 0; i < lim && rd[n] !== 1'b1; i++)
            bus(1'b0, cca_pkg::OFS_FLAG, 32'h00000000);
    endtask : wait_flag

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task t_reset;
        rdc(cca_pkg::OFS_CTRL, 32'h00000000);
        rdc(cca_pkg::OFS_FLAG, 32'h00000000);
        rdc(cca_pkg::OFS_CNT, 32'h00000000);
        wr(8'h1C, 32'h000000FF);
        rdc(8'h1C, 32'h00000000);
        check(b(hresp), 32'h0);
    endtask : t_reset

    task t_timer;
        wr(cca_pkg::OFS_MODE, 32'h09);
        wr(cca_pkg::OFS_CMPL, 32'h80);
        wr(cca_pkg::OFS_CMPH, 32'h00);
        rdc(cca_pkg::OFS_MODE, 32'h49);
        wr(cca_pkg::OFS_CMPL, 32'h80);
        rdc(cca_pkg::OFS_MODE, 32'h09);
        wr(cca_pkg::OFS_CMPH, 32'h00);
        wr(cca_pkg::OFS_CTRL, 32'h01);
        wait_flag(2, 200);
        check(b(rd[2]), 32'h1);
        check(b(irq), 32'h0);
        wr(cca_pkg::OFS_CTRL, 32'h0D);
        repeat (3) @(posedge i_clk);
        check(b(irq), 32'h1);
        bus(1'b0, cca_pkg::OFS_FLAG, 32'h00000000);
        check(b(rd[2]), 32'h1);
        wr(cca_pkg::OFS_FLAG, 32'h04);
        repeat (3) @(posedge i_clk);
        check(b(irq), 32'h0);
        wr(cca_pkg::OFS_MODE, 32'h00);
    endtask : t_timer

    task t_toggle_wrap;
        wr(cca_pkg::OFS_MODE + 8'h04, 32'h0C);
        bus(1'b0, cca_pkg::OFS_CNT, 32'h00000000);
        c = rd[15:0] + 16'h0100;
        wr(cca_pkg::OFS_CMPL + 8'h04, {24'h000000, c[7:0]});
        wr(cca_pkg::OFS_CMPH + 8'h04, {24'h000000, c[15:8]});
        wait_flag(3, 300);
        repeat (2) @(posedge i_clk);
        check(b(pin_out[1]), 32'h1);
        // Comparator off: the next lap's match must leave the pin alone
        wr(cca_pkg::OFS_CMPL + 8'h04, {24'h000000, c[7:0]});
        wr(cca_pkg::OFS_FLAG, 32'h000000FF);
        wait_flag(0, 40000);
        check({30'h00000000, rd[1:0]}, 32'h3);
        repeat (1200) @(posedge i_clk);
        check(b(pin_out[1]), 32'h1);
        check(b(irq), 32'h0);
        wr(cca_pkg::OFS_CTRL, 32'h0F);
        repeat (3) @(posedge i_clk);
        check(b(irq), 32'h1);
        wr(cca_pkg::OFS_CTRL, 32'h0C);
        wr(cca_pkg::OFS_FLAG, 32'h000000FF);
        repeat (3) @(posedge i_clk);
        check(b(irq), 32'h0);
    endtask : t_toggle_wrap

    task t_capture;
        logic [7:0] m [3];
        m = '{8'h20, 8'h10, 8'h30};
        bus(1'b0, cca_pkg::OFS_CNT, 32'h00000000);
        c = rd[15:0];
        for (int i = 0; i < 3; i++)
        begin
            wr(cca_pkg::OFS_MODE + 8'h08, {24'h000000, m[i]});
            wr(cca_pkg::OFS_FLAG, 32'h000000FF);
            lvl[2] <= 1'b1;
            repeat (5) @(posedge i_clk);
            bus(1'b0, cca_pkg::OFS_FLAG, 32'h00000000);
            check(b(rd[4]), b(m[i][5]));
            bus(1'b0, cca_pkg::OFS_PIN, 32'h00000000);
            check(b(rd[2]), 32'h1);
            wr(cca_pkg::OFS_FLAG, 32'h000000FF);
            lvl[2] <= 1'b0;
            repeat (5) @(posedge i_clk);
            bus(1'b0, cca_pkg::OFS_FLAG, 32'h00000000);
            check(b(rd[4]), b(m[i][4]));
        end
        rdc(cca_pkg::OFS_CMPL + 8'h08, {24'h000000, c[7:0]});
        rdc(cca_pkg::OFS_CMPH + 8'h08, {24'h000000, c[15:8]});
    endtask : t_capture

    task t_view;
        wr(cca_pkg::OFS_PCFG, 32'h83);
        rdc(cca_pkg::OFS_PCFG, 32'h83);
        wr(cca_pkg::OFS_CMPL + 8'h0C, 32'h5A);
        rdc(cca_pkg::OFS_CMPL + 8'h0C, 32'h5A);
        wr(cca_pkg::OFS_PCFG, 32'h03);
        rdc(cca_pkg::OFS_CMPL + 8'h0C, 32'h00);
    endtask : t_view

    // Short and wide pulse modes on channel 4
    task t_pulse;
        wr(cca_pkg::OFS_PCFG, 32'h00);
        wr(cca_pkg::OFS_MODE + 8'h10, 32'h0A);
        wr(cca_pkg::OFS_CMPL + 8'h10, 32'h80);
        wr(cca_pkg::OFS_CMPH + 8'h10, 32'h80);
        wr(cca_pkg::OFS_CTRL, 32'h01);
        wr(cca_pkg::OFS_FLAG, 32'h000000FF);
        wait_flag(6, 300);
        check(b(pin_out[4]), 32'h1);
        wr(cca_pkg::OFS_FLAG, 32'h00000002);
        wait_flag(1, 300);
        check(b(pin_out[4]), 32'h0);
        // Wide mode: rise at the full 16-bit match
        wr(cca_pkg::OFS_MODE + 8'h10, 32'h8A);
        bus(1'b0, cca_pkg::OFS_CNT, 32'h00000000);
        c = rd[15:0] + 16'h0100;
        wr(cca_pkg::OFS_CMPL + 8'h10, {24'h000000, c[7:0]});
        wr(cca_pkg::OFS_CMPH + 8'h10, {24'h000000, c[15:8]});
        wr(cca_pkg::OFS_FLAG, 32'h000000FF);
        wait_flag(6, 300);
        check(b(pin_out[4]), 32'h1);
        // Comparator off forces the pulse output low
        wr(cca_pkg::OFS_CMPL + 8'h10, {24'h000000, c[7:0]});
        repeat (2) @(posedge i_clk);
        check(b(pin_out[4]), 32'h0);
    endtask : t_pulse

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        t_reset();
        t_timer();
        t_toggle_wrap();
        t_capture();
        t_view();
        t_pulse();
        print_verdict();
    end
endmodule : counter_array_capture_compare_tb_top
